// >>> hw/bms_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module bms_sequencer (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // asynchronous pins and comparator levels
   input wire logic slow_crystal_clock,
   input wire logic engine_clock,
   input wire logic supply_fault_input,
   input wire logic aux_compare_input,
   input wire logic regulator_margin_ok,
   input wire logic pushbutton_pin,
   input wire logic wake_timer_expired,
   input wire logic pll_good,
   // converter
   input wire logic [15:0] adc_result,
   output logic [3:0] conv_channel,
   output logic conv_start,
   output logic ram_wr_en,
   output logic [3:0] ram_wr_addr,
   output logic [15:0] ram_wr_data,
   // engine
   output logic ce_pass_start,
   output logic ce_busy,
   output logic transfer_busy_event,
   output logic realtime_monitor_stream,
   // mode and power
   output bms_pkg::bms_mode_t mode,
   output logic adc_enable,
   output logic ce_enable,
   output logic mpu_from_crystal,
   output logic [2:0] mpu_div_active,
   output logic mpu_crystal_tick,
   output logic display_on,
   output logic core_domain_on,
   output logic [7:0] irq_flags,
   output logic test_mux_pin
);
   bms_pkg::bms_state_t q;
   bms_pkg::bms_state_t d;
   logic [7:0] pins;
   logic slow_tick;
   logic ce_tick;
   logic pb_rise;
   logic wake_rise;
   logic supply_ok;
   logic pll_ok;
   logic margin_ok;
   logic mission_ok;
   logic seq_on;
   logic [8:0] pass_len;
   logic [15:0] group_len;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;

   assign pins = {pll_good, wake_timer_expired, pushbutton_pin, regulator_margin_ok,
                  aux_compare_input, supply_fault_input, engine_clock, slow_crystal_clock};
   assign slow_tick = q.s2[bms_pkg::PIN_SLOW_CLK] & ~q.s3[bms_pkg::PIN_SLOW_CLK];
   assign ce_tick = q.s2[bms_pkg::PIN_CE_CLK] & ~q.s3[bms_pkg::PIN_CE_CLK];
   assign pb_rise = q.s2[bms_pkg::PIN_PUSHBUTTON] & ~q.s3[bms_pkg::PIN_PUSHBUTTON];
   assign wake_rise = q.s2[bms_pkg::PIN_WAKE] & ~q.s3[bms_pkg::PIN_WAKE];
   assign supply_ok = q.s2[bms_pkg::PIN_SUPPLY_OK];
   assign pll_ok = q.s2[bms_pkg::PIN_PLL_OK];
   assign margin_ok = q.s2[bms_pkg::PIN_MARGIN_OK];
   assign mission_ok = supply_ok & pll_ok;
   // converter and engine only run in mission with the PLL good
   assign seq_on = q.adc_en & pll_ok & (q.mode == bms_pkg::BMS_MISSION);
   assign group_len = q.presample * q.sum_cycle_count;

   always_comb begin
      case (q.fir)
         2'h0: pass_len = bms_pkg::PASS_LEN_0;
         2'h1: pass_len = bms_pkg::PASS_LEN_1;
         default: pass_len = bms_pkg::PASS_LEN_2;
      endcase
   end

   always_comb begin
      d = q;
      flag_set = 8'h00;
      flag_clr = 8'h00;
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.conv_start = 1'b0;
      d.conv_done = 1'b0;
      d.pass_start = 1'b0;
      d.xfer = 1'b0;
      d.mpu_tick = 1'b0;
      d.rdata = 8'h00;

      // operating mode
      case (q.mode)
         bms_pkg::BMS_MISSION: begin
            if (!supply_ok) begin
               flag_set[bms_pkg::FLAG_PLL_FALL] = 1'b1;
               if (!margin_ok) begin
                  d.mode = bms_pkg::BMS_SLEEP;
               end else begin
                  d.mode = bms_pkg::BMS_BROWNOUT;
               end
            end else if (!pll_ok) begin
               flag_set[bms_pkg::FLAG_PLL_FALL] = 1'b1;
               d.mode = bms_pkg::BMS_BROWNOUT;
            end
         end
         bms_pkg::BMS_BROWNOUT: begin
            if (mission_ok) begin
               d.mode = bms_pkg::BMS_MISSION;
               flag_set[bms_pkg::FLAG_PLL_RISE] = 1'b1;
            end else if (!margin_ok && !supply_ok) begin
               d.mode = bms_pkg::BMS_SLEEP;
            end else if (q.sleep_req) begin
               // firmware choice between the two low-power modes; sleep has priority
               d.mode = bms_pkg::BMS_SLEEP;
            end else if (q.display_req) begin
               d.mode = bms_pkg::BMS_DISPLAY_ONLY;
            end
         end
         bms_pkg::BMS_DISPLAY_ONLY, bms_pkg::BMS_SLEEP: begin
            // margin returning is no exit: only power, timer or button wake the part
            if (mission_ok) begin
               d.mode = bms_pkg::BMS_MISSION;
               flag_set[bms_pkg::FLAG_PLL_RISE] = 1'b1;
            end else if (pb_rise || wake_rise) begin
               d.mode = bms_pkg::BMS_BROWNOUT;
               flag_set[bms_pkg::FLAG_PUSHBUTTON] = pb_rise;
               flag_set[bms_pkg::FLAG_WAKE] = wake_rise;
            end else if (q.mode == bms_pkg::BMS_DISPLAY_ONLY && !margin_ok) begin
               d.mode = bms_pkg::BMS_SLEEP;
            end
         end
         default: d.mode = bms_pkg::BMS_BROWNOUT;
      endcase
      // a request is consumed once the part leaves brownout
      if (q.mode != bms_pkg::BMS_BROWNOUT) begin
         d.sleep_req = 1'b0;
         d.display_req = 1'b0;
      end

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            bms_pkg::ADDR_FLAGS: flag_clr = reg_wdata;
            bms_pkg::ADDR_CONTROL: begin
               d.sleep_req = reg_wdata[bms_pkg::CTL_SLEEP];
               d.display_req = reg_wdata[bms_pkg::CTL_DISPLAY];
            end
            bms_pkg::ADDR_TEST_MUX: d.tmux = reg_wdata[4:0];
            bms_pkg::ADDR_FRAME: begin
               d.slot_count = reg_wdata[3:0];
               d.fir = reg_wdata[5:4];
            end
            bms_pkg::ADDR_SLOT0: d.slot_zero_channel_select = reg_wdata[3:0];
            bms_pkg::ADDR_PRESAMPLE: d.presample = reg_wdata;
            bms_pkg::ADDR_SUM_CYCLE_COUNT: d.sum_cycle_count = reg_wdata;
            bms_pkg::ADDR_ENABLES: begin
               d.adc_en = reg_wdata[0];
               d.ce_en = reg_wdata[1];
               d.mpu_div = reg_wdata[4:2];
            end
            default: d.rdata = 8'h00;
         endcase
      end
      // hardware set wins over a software clear in the same cycle
      d.flags = (q.flags & ~flag_clr) | flag_set;

      // register reads, data valid in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            bms_pkg::ADDR_FLAGS: d.rdata = q.flags;
            bms_pkg::ADDR_CONTROL: d.rdata = {1'b0, q.sleep_req, q.display_req, 5'h00};
            bms_pkg::ADDR_TEST_MUX: d.rdata = {3'h0, q.tmux};
            bms_pkg::ADDR_FRAME: d.rdata = {2'h0, q.fir, q.slot_count};
            bms_pkg::ADDR_SLOT0: d.rdata = {4'h0, q.slot_zero_channel_select};
            bms_pkg::ADDR_PRESAMPLE: d.rdata = q.presample;
            bms_pkg::ADDR_SUM_CYCLE_COUNT: d.rdata = q.sum_cycle_count;
            bms_pkg::ADDR_ENABLES: d.rdata = {3'h0, q.mpu_div, q.ce_en, q.adc_en};
            bms_pkg::ADDR_STATUS: d.rdata = {3'h0, ce_busy, margin_ok, pll_ok, q.mode};
            default: d.rdata = 8'h00;
         endcase
      end

      // multiplexer frame: slot_count conversions of fir+1 slow cycles, then one recovery cycle
      if (!seq_on) begin
         d.slot = 4'h0;
         d.sub = 2'h0;
         d.recov = 1'b1;
      end else if (slow_tick) begin
         if (q.recov) begin
            if (q.slot_count != 4'h0) begin
               d.recov = 1'b0;
               d.slot = 4'h0;
               d.sub = 2'h0;
               d.conv_start = 1'b1;
               d.pass_start = 1'b1;
            end
         end else if (q.sub == q.fir) begin
            d.conv_done = 1'b1;
            d.ram_addr = q.slot;
            d.ram_data = adc_result;
            d.sub = 2'h0;
            if (q.slot == q.slot_count - 4'h1) begin
               d.recov = 1'b1;
               d.rtm_cnt = bms_pkg::RTM_LEN;
            end else begin
               d.slot = q.slot + 4'h1;
               d.conv_start = 1'b1;
            end
         end else begin
            d.sub = q.sub + 2'h1;
         end
      end

      // engine pass of fixed length, independent of data
      if (!seq_on || !q.ce_en) begin
         d.ce_cnt = 9'h000;
         d.pass_cnt = 16'h0000;
      end else if (q.pass_start) begin
         d.ce_cnt = pass_len;
         if (q.pass_cnt + 16'h0001 >= group_len) begin
            d.pass_cnt = 16'h0000;
            d.xfer = 1'b1;
         end else begin
            d.pass_cnt = q.pass_cnt + 16'h0001;
         end
      end else if (ce_tick && q.ce_cnt != 9'h000) begin
         d.ce_cnt = q.ce_cnt - 9'h001;
      end

      // monitor stream, cut off at the next pass in case the engine clock stalls
      if (!seq_on || q.pass_start) begin
         d.rtm_cnt = 8'h00;
      end else if (ce_tick && q.rtm_cnt != 8'h00 && !(slow_tick && q.recov)) begin
         d.rtm_cnt = q.rtm_cnt - 8'h01;
      end

      // brownout processor clock: swallow every eighth crystal edge
      if (q.mode == bms_pkg::BMS_BROWNOUT && slow_tick) begin
         d.mpu_phase = q.mpu_phase + 3'h1;
         d.mpu_tick = (q.mpu_phase != bms_pkg::BROWNOUT_SWALLOW);
      end

      case (q.tmux)
         bms_pkg::TMUX_AUX_CMP: d.tmux_out = q.s2[bms_pkg::PIN_AUX_CMP];
         bms_pkg::TMUX_CE_BUSY: d.tmux_out = ce_busy;
         bms_pkg::TMUX_TRANSFER_BUSY_EVENT: d.tmux_out = q.xfer;
         default: d.tmux_out = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q <= '0;
         // margin reads good until the synchroniser fills, else every reset on battery would fall into sleep
         q.s1 <= 8'(1 << bms_pkg::PIN_MARGIN_OK);
         q.s2 <= 8'(1 << bms_pkg::PIN_MARGIN_OK);
         q.s3 <= 8'(1 << bms_pkg::PIN_MARGIN_OK);
         q.mode <= bms_pkg::BMS_BROWNOUT;
         q.slot_count <= bms_pkg::RST_SLOT_COUNT;
         q.fir <= bms_pkg::RST_FIR;
         q.presample <= bms_pkg::RST_PRESAMPLE;
         q.sum_cycle_count <= bms_pkg::RST_SUM_CYCLE_COUNT;
         q.recov <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign conv_channel = (q.slot == 4'h0) ? q.slot_zero_channel_select : q.slot;
   assign conv_start = q.conv_start;
   assign ram_wr_en = q.conv_done;
   assign ram_wr_addr = q.ram_addr;
   assign ram_wr_data = q.ram_data;
   assign ce_pass_start = q.pass_start;
   assign ce_busy = (q.ce_cnt != 9'h000);
   assign transfer_busy_event = q.xfer;
   assign realtime_monitor_stream = (q.rtm_cnt != 8'h00);
   assign mode = q.mode;
   assign adc_enable = q.adc_en & pll_ok;
   assign ce_enable = q.ce_en & pll_ok;
   assign mpu_from_crystal = (q.mode == bms_pkg::BMS_BROWNOUT);
   assign mpu_div_active = (q.mode == bms_pkg::BMS_MISSION) ? q.mpu_div : 3'h0;
   assign mpu_crystal_tick = q.mpu_tick;
   assign display_on = (q.mode != bms_pkg::BMS_SLEEP);
   assign core_domain_on = (q.mode == bms_pkg::BMS_MISSION) || (q.mode == bms_pkg::BMS_BROWNOUT);
   assign irq_flags = q.flags;
   assign test_mux_pin = q.tmux_out;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   property p_tmux_aux;
      (q.tmux == bms_pkg::TMUX_AUX_CMP) ##1 (q.tmux == bms_pkg::TMUX_AUX_CMP)
         |-> test_mux_pin == $past(q.s2[bms_pkg::PIN_AUX_CMP]);
   endproperty
   a_tmux_aux: assert property (p_tmux_aux) else $error("test pin does not follow aux comparator");

   property p_frame_end;
      seq_on && slow_tick && !q.recov && q.sub == q.fir && q.slot == q.slot_count - 4'h1 |=> q.recov;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("frame did not end after last slot");

   property p_recov_one;
      seq_on && slow_tick && q.recov && q.slot_count != 4'h0 |=> !q.recov && conv_start;
   endproperty
   a_recov_one: assert property (p_recov_one) else $error("recovery lasted more than one slow cycle");

   property p_pass_slot0;
      ce_pass_start |-> conv_start && conv_channel == q.slot_zero_channel_select;
   endproperty
   a_pass_slot0: assert property (p_pass_slot0) else $error("pass start not aligned to slot 0");

   property p_pass_len;
      ce_pass_start && q.ce_en && seq_on |=> q.ce_cnt == $past(pass_len);
   endproperty
   a_pass_len: assert property (p_pass_len) else $error("pass length wrong");

   property p_ram_pulse;
      ram_wr_en |=> !ram_wr_en;
   endproperty
   a_ram_pulse: assert property (p_ram_pulse) else $error("ram write longer than one cycle");

   property p_rtm_start;
      $rose(realtime_monitor_stream) |-> q.recov && q.rtm_cnt == bms_pkg::RTM_LEN;
   endproperty
   a_rtm_start: assert property (p_rtm_start) else $error("monitor stream began outside final state");

   property p_rtm_done;
      ce_pass_start |=> !realtime_monitor_stream;
   endproperty
   a_rtm_done: assert property (p_rtm_done) else $error("monitor stream overlaps next pass");

   property p_enable_hold;
      !pll_ok |-> !adc_enable && !ce_enable && !seq_on;
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enables not held while PLL bad");

   property p_mission_leave;
      mode == bms_pkg::BMS_MISSION && !mission_ok |=> mode != bms_pkg::BMS_MISSION;
   endproperty
   a_mission_leave: assert property (p_mission_leave) else $error("mission kept without power or PLL");

   property p_pll_fall;
      mode == bms_pkg::BMS_MISSION && !mission_ok |=> irq_flags[bms_pkg::FLAG_PLL_FALL];
   endproperty
   a_pll_fall: assert property (p_pll_fall) else $error("PLL-fall flag not set");

   property p_pll_rise;
      $rose(mode == bms_pkg::BMS_MISSION) |-> irq_flags[bms_pkg::FLAG_PLL_RISE];
   endproperty
   a_pll_rise: assert property (p_pll_rise) else $error("PLL-rise flag not set");

   property p_sleep_stays;
      mode == bms_pkg::BMS_SLEEP && !mission_ok && !pb_rise && !wake_rise |=> mode == bms_pkg::BMS_SLEEP;
   endproperty
   a_sleep_stays: assert property (p_sleep_stays) else $error("sleep left without wake event");

   property p_sleep_req;
      mode == bms_pkg::BMS_BROWNOUT && q.sleep_req && !mission_ok |=> mode == bms_pkg::BMS_SLEEP;
   endproperty
   a_sleep_req: assert property (p_sleep_req) else $error("sleep request not honoured");
endmodule
`default_nettype wire

// >>> hw/bms_pkg.sv
// Summary of operation
// - Aux comparator output high while its input exceeds bias; shown on test pin at 0x16.
// - Multiplexer frame lasts one plus slot count times (filter code plus one) slow cycles.
// - Conversions take whole slow cycles; one recovery slow cycle precedes the next frame.
// - Engine pass starts when the slot 0 conversion starts; slot 0 channel is selectable.
// - Every engine pass lasts a fixed engine-clock count set by the filter code (138, 288 or 384).
// - Each conversion result is written to shared RAM when that conversion completes.
// - Monitor stream starts with the final frame state, lasts 140 engine cycles, ends first.
// - Transfer-busy pulses once per presample count times sum cycle count passes.
// - Mission mode only with system power and stable PLL; metering runs only there.
// - Brownout entered on supply fault while margin is good, and on wake while on battery.
// - Brownout leaves for display-only only on its firmware request; for sleep on request or on low margin without power.
// - Mission to brownout sets the PLL-fall flag, bit 7.
// - Return to mission with PLL stable sets the PLL-rise flag, bit 6.
// - Writing one to bit 6 of control register 0x20a9 requests sleep.
// - Display-only or sleep left for brownout only on wake timer (bit 5) or pushbutton (bit 4).
// - Without system power, low regulator margin forces sleep.
// - After margin-forced sleep, stay asleep even when margin recovers.
// - Processor clock from PLL over divider in mission; 7/8 crystal rate in brownout.
// - When power returns, any battery mode goes to mission once the PLL settles.
// - While PLL not good, ADC and engine enables are held at zero.
package bms_pkg;
   // register byte addresses on the 8-bit register port
   localparam logic [15:0] ADDR_FLAGS = 16'h00e8;
   localparam logic [15:0] ADDR_CONTROL = 16'h20a9;
   localparam logic [15:0] ADDR_TEST_MUX = 16'h20aa;
   localparam logic [15:0] ADDR_FRAME = 16'h2100;
   localparam logic [15:0] ADDR_SLOT0 = 16'h2101;
   localparam logic [15:0] ADDR_PRESAMPLE = 16'h2102;
   localparam logic [15:0] ADDR_SUM_CYCLE_COUNT = 16'h2103;
   localparam logic [15:0] ADDR_ENABLES = 16'h2104;
   localparam logic [15:0] ADDR_STATUS = 16'h2105;
   // field positions
   localparam int FLAG_PLL_FALL = 7;
   localparam int FLAG_PLL_RISE = 6;
   localparam int FLAG_WAKE = 5;
   localparam int FLAG_PUSHBUTTON = 4;
   localparam int CTL_SLEEP = 6;
   localparam int CTL_DISPLAY = 5;
   // synchroniser bit positions of the pin vector
   localparam int PIN_SLOW_CLK = 0;
   localparam int PIN_CE_CLK = 1;
   localparam int PIN_SUPPLY_OK = 2;
   localparam int PIN_AUX_CMP = 3;
   localparam int PIN_MARGIN_OK = 4;
   localparam int PIN_PUSHBUTTON = 5;
   localparam int PIN_WAKE = 6;
   localparam int PIN_PLL_OK = 7;
   // test multiplexer codes
   localparam logic [4:0] TMUX_AUX_CMP = 5'h16;
   localparam logic [4:0] TMUX_CE_BUSY = 5'h1e;
   localparam logic [4:0] TMUX_TRANSFER_BUSY_EVENT = 5'h1f;
   // timing in engine-clock cycles; brownout swallow phase in crystal edges
   localparam logic [8:0] PASS_LEN_0 = 9'd138;
   localparam logic [8:0] PASS_LEN_1 = 9'd288;
   localparam logic [8:0] PASS_LEN_2 = 9'd384;
   localparam logic [7:0] RTM_LEN = 8'd140;
   localparam logic [2:0] BROWNOUT_SWALLOW = 3'h7;
   // reset values
   localparam logic [3:0] RST_SLOT_COUNT = 4'h6;
   localparam logic [1:0] RST_FIR = 2'h1;
   localparam logic [7:0] RST_PRESAMPLE = 8'h01;
   localparam logic [7:0] RST_SUM_CYCLE_COUNT = 8'h01;

   typedef enum logic [1:0] {
      BMS_MISSION,
      BMS_BROWNOUT,
      BMS_DISPLAY_ONLY,
      BMS_SLEEP
   } bms_mode_t;

   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      bms_mode_t mode;
      logic [7:0] flags;
      logic sleep_req;
      logic display_req;
      logic [4:0] tmux;
      logic [3:0] slot_count;
      logic [1:0] fir;
      logic [3:0] slot_zero_channel_select;
      logic [7:0] presample;
      logic [7:0] sum_cycle_count;
      logic adc_en;
      logic ce_en;
      logic [2:0] mpu_div;
      logic [3:0] slot;
      logic [1:0] sub;
      logic recov;
      logic conv_start;
      logic conv_done;
      logic pass_start;
      logic [3:0] ram_addr;
      logic [15:0] ram_data;
      logic [8:0] ce_cnt;
      logic [15:0] pass_cnt;
      logic xfer;
      logic [7:0] rtm_cnt;
      logic [2:0] mpu_phase;
      logic mpu_tick;
      logic tmux_out;
      logic [7:0] rdata;
   } bms_state_t;
endpackage

// >>> testbench/bms_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bms_partner #(
   parameter int PLL_SETTLE = 16
) (
   // system side
   input wire logic core_clk,
   input wire logic power_on,
   // pins toward the sequencer
   output logic slow_crystal_clock,
   output logic engine_clock,
   output logic supply_fault_input,
   output logic pll_good,
   output logic [15:0] adc_result
);
   int settle = 0;
   logic [15:0] sample = 16'h1357;
   initial begin
      {slow_crystal_clock, engine_clock, supply_fault_input, pll_good} = 4'h0;
      adc_result = 16'h0000;
      fork
         forever #15258.789 slow_crystal_clock = ~slow_crystal_clock;
         forever #101.725 engine_clock = ~engine_clock;
      join
   end
   // new sample mid slow cycle, so it is settled whenever a conversion ends
   always @(negedge slow_crystal_clock) sample = sample + 16'h0101;
   // comparator follows power at once; the pll reports good only after settling
   always @(posedge core_clk) begin
      settle = power_on ? settle + 1 : 0;
      supply_fault_input <= power_on;
      pll_good <= power_on && settle > PLL_SETTLE;
      adc_result <= sample;
   end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk, reset, reg_wr, reg_rd, power_on, aux_compare_input, regulator_margin_ok;
   logic pushbutton_pin, wake_timer_expired, slow_crystal_clock, engine_clock, supply_fault_input, pll_good;
   logic conv_start, ram_wr_en, ce_pass_start, ce_busy, transfer_busy_event, realtime_monitor_stream;
   logic adc_enable, ce_enable, mpu_from_crystal, mpu_crystal_tick, display_on, core_domain_on, test_mux_pin;
   logic [15:0] reg_addr, adc_result, ram_wr_data;
   logic [7:0] reg_wdata, reg_rdata, irq_flags;
   logic [3:0] conv_channel, ram_wr_addr;
   logic [2:0] mpu_div_active;
   bms_pkg::bms_mode_t mode;
   int miscompares = 0, compares = 0, passes = 0, passes_x = 0, slow_n = 0, conv_n = 0;
   int busy_n = 0, rtm_n = 0, ticks = 0, exp_frame = 0, exp_busy = 0, exp_x = 1, f, t;
   bit arm = 0, seen_x = 0, slow_d = 0, eng_d = 0;
   int plen[3] = '{138, 288, 384};

   bms_partner i_bms_partner (.core_clk, .power_on, .slow_crystal_clock, .engine_clock, .supply_fault_input,
      .pll_good, .adc_result);
   bms_sequencer i_bms_sequencer (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .slow_crystal_clock, .engine_clock, .supply_fault_input, .aux_compare_input, .regulator_margin_ok,
      .pushbutton_pin, .wake_timer_expired, .pll_good, .adc_result, .conv_channel, .conv_start, .ram_wr_en,
      .ram_wr_addr, .ram_wr_data, .ce_pass_start, .ce_busy, .transfer_busy_event, .realtime_monitor_stream,
      .mode, .adc_enable, .ce_enable, .mpu_from_crystal, .mpu_div_active, .mpu_crystal_tick, .display_on,
      .core_domain_on, .irq_flags, .test_mux_pin);

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(16'(reg_rdata), 16'(e));
   endtask
   task automatic wait_mode(input bms_pkg::bms_mode_t m);
      for (t = 0; t < 40 && mode !== m; t++) begin
         @(posedge core_clk);
         #1;
      end
      chk(16'(mode), 16'(m));
   endtask
   task automatic wait_pass(input int n);
      int goal;
      goal = passes + n;
      for (t = 0; t < 4000 * n && passes < goal; t++) @(posedge core_clk);
      chk(16'(passes >= goal), 16'h0001);
   endtask

   // frame observer: raw pin edges are counted, so the sync delay cancels between pass starts
   always @(posedge core_clk) begin
      if (transfer_busy_event) begin
         if (arm && seen_x) chk(16'(passes_x), 16'(exp_x));
         seen_x = 1;
         passes_x = 0;
      end
      if (ce_pass_start) begin
         if (arm) begin
            chk(16'(slow_n), 16'(exp_frame));
            chk(16'(conv_n), 16'h0002);
            chk(16'(conv_channel), 16'h0005);
            chk(16'(realtime_monitor_stream), 16'h0000);
            chk(16'(busy_n >= exp_busy - 1 && busy_n <= exp_busy + 1), 16'h0001);
            chk(16'(rtm_n >= 139 && rtm_n <= 141), 16'h0001);
         end
         passes++;
         passes_x++;
         {slow_n, conv_n, busy_n, rtm_n} = '0;
      end
      if (arm && ram_wr_en) chk(ram_wr_data, adc_result);
      if (arm && ram_wr_en) chk(16'(ram_wr_addr), 16'(conv_n - 1));
      if (slow_crystal_clock && !slow_d) slow_n++;
      if (engine_clock && !eng_d && ce_busy) busy_n++;
      if (engine_clock && !eng_d && realtime_monitor_stream) rtm_n++;
      if (conv_start) conv_n++;
      if (mpu_crystal_tick) ticks++;
      slow_d = slow_crystal_clock;
      eng_d = engine_clock;
   end

   initial begin
      #9_000_000;
      miscompares++;
      conclude();
   end

   initial begin
      {reset, regulator_margin_ok} = 2'b11;
      {reg_wr, reg_rd, power_on, aux_compare_input, pushbutton_pin, wake_timer_expired} = '0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1 chk(16'(mode), 16'(bms_pkg::BMS_BROWNOUT));
      rd(bms_pkg::ADDR_FRAME, 8'h16);
      rd(bms_pkg::ADDR_PRESAMPLE, 8'h01);
      rd(bms_pkg::ADDR_SUM_CYCLE_COUNT, 8'h01);
      rd(bms_pkg::ADDR_ENABLES, 8'h00);
      rd(16'h2106, 8'h00);
      chk(16'(mode), 16'(bms_pkg::BMS_BROWNOUT));
      @(posedge core_clk) power_on <= 1'b1;
      wait_mode(bms_pkg::BMS_MISSION);
      rd(bms_pkg::ADDR_FLAGS, 8'h40);
      wr(bms_pkg::ADDR_FLAGS, 8'hff);
      rd(bms_pkg::ADDR_FLAGS, 8'h00);
      wr(bms_pkg::ADDR_TEST_MUX, 8'h16);
      for (f = 0; f < 3; f++) begin
         @(posedge core_clk) aux_compare_input <= (f == 1);
         repeat (8) @(posedge core_clk);
         #1 chk(16'(test_mux_pin), 16'(f == 1));
      end
      wr(bms_pkg::ADDR_SLOT0, 8'h05);
      wr(bms_pkg::ADDR_ENABLES, 8'h0f);
      for (f = 0; f < 3; f++) begin
         arm = 0;
         wr(bms_pkg::ADDR_FRAME, {2'b00, 2'(f), 4'h2});
         exp_frame = 1 + 2 * (f + 1);
         exp_busy = plen[f];
         seen_x = 0;
         wait_pass(2);
         arm = 1;
         wait_pass(4);
      end
      arm = 0;
      wr(bms_pkg::ADDR_PRESAMPLE, 8'h02);
      wr(bms_pkg::ADDR_SUM_CYCLE_COUNT, 8'h02);
      exp_x = 4;
      seen_x = 0;
      wait_pass(2);
      arm = 1;
      wait_pass(9);
      arm = 0;
      #1 chk(16'(mpu_div_active), 16'h0003);
      @(posedge core_clk) power_on <= 1'b0;
      wait_mode(bms_pkg::BMS_BROWNOUT);
      chk(16'({adc_enable, ce_enable, mpu_from_crystal, mpu_div_active}), 16'h0008);
      rd(bms_pkg::ADDR_FLAGS, 8'h80);
      chk(16'(irq_flags), 16'h0080);
      rd(bms_pkg::ADDR_STATUS, 8'h09);
      @(posedge slow_crystal_clock);
      f = ticks;
      t = passes;
      repeat (16) @(posedge slow_crystal_clock);
      chk(16'(ticks - f), 16'd14);
      chk(16'(passes - t), 16'd0);
      wr(bms_pkg::ADDR_FLAGS, 8'hff);
      wr(bms_pkg::ADDR_CONTROL, 8'h20);
      wait_mode(bms_pkg::BMS_DISPLAY_ONLY);
      chk(16'({display_on, core_domain_on}), 16'h0002);
      @(posedge core_clk) pushbutton_pin <= 1'b1;
      wait_mode(bms_pkg::BMS_BROWNOUT);
      rd(bms_pkg::ADDR_FLAGS, 8'h10);
      wr(bms_pkg::ADDR_FLAGS, 8'hff);
      pushbutton_pin <= 1'b0;
      // firmware parks the part in sleep once power is gone
      wr(bms_pkg::ADDR_CONTROL, 8'h40);
      wait_mode(bms_pkg::BMS_SLEEP);
      chk(16'(display_on), 16'h0000);
      @(posedge core_clk) wake_timer_expired <= 1'b1;
      wait_mode(bms_pkg::BMS_BROWNOUT);
      rd(bms_pkg::ADDR_FLAGS, 8'h20);
      wr(bms_pkg::ADDR_FLAGS, 8'hff);
      wake_timer_expired <= 1'b0;
      @(posedge core_clk) regulator_margin_ok <= 1'b0;
      wait_mode(bms_pkg::BMS_SLEEP);
      @(posedge core_clk) regulator_margin_ok <= 1'b1;
      repeat (20) @(posedge core_clk);
      #1 chk(16'(mode), 16'(bms_pkg::BMS_SLEEP));
      @(posedge core_clk) power_on <= 1'b1;
      wait_mode(bms_pkg::BMS_MISSION);
      rd(bms_pkg::ADDR_FLAGS, 8'h40);
      conclude();
   end
endmodule
`default_nettype wire
